// ===== src/conv_ctrl_defs.vh
// Constants for the converter control and output clocking block
`ifndef CONV_CTRL_DEFS_VH
`define CONV_CTRL_DEFS_VH

// Serial frame layout
`define FRAME_BITS        6'd32
`define FRAME_HEADER      12'h001
`define HDR_HI            31
`define HDR_LO            20
`define ADDR_HI           19
`define ADDR_LO           16
`define DATA_HI           15
`define DATA_LO           0

// Register addresses
`define ADDR_CONFIG       4'h1
`define ADDR_OFFSET       4'h2
`define ADDR_FULL_SCALE   4'h3
`define ADDR_PHASE_FINE   4'hd
`define ADDR_PHASE_COARSE 4'he
`define ADDR_TEST_BUFFER  4'hf

// Reset values
`define CONFIG_RESET      16'h9eff
`define OFFSET_RESET      16'h0000
`define FULL_SCALE_RESET  16'h8000
`define PHASE_FINE_RESET  16'h0000
`define PHASE_COARSE_RESET 16'h0000
`define TEST_BUFFER_RESET 16'h0000

// Configuration fields
`define CFG_DIFF_RESET    14
`define CFG_RES_TRIM_DIS  13
`define CFG_DUTY_STAB     12
`define CFG_DDR_PHASE     11
`define CFG_DDR_DISABLE   10
`define CFG_OUT_EDGE      8

// Nine-bit code fields
`define CODE_HI           15
`define CODE_LO           7

// Test pattern register fields
`define TP_ENABLE         11

// Full-scale, offset and phase codes in normal control
`define FS_CODE_PIN_LOW   9'h0d8
`define FS_CODE_PIN_HIGH  9'h128
`define OFFSET_CODE_ZERO  9'h000
`define PHASE_ZERO        16'h0000

// Background phase trim
`define TRIM_PERIOD       4'hf
`define TRIM_MID          6'h20
`define TRIM_MAX          6'h3f
`define TRIM_MIN          6'h00

// Test pattern start
`define TP_SEED           8'h55

`endif

// ===== src/two_entry_buffer.v
// Two-entry valid/ready buffer between sample intake and output stage
`default_nettype none

module two_entry_buffer #(
  parameter WIDTH = 16
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem_q [0:1];
  reg             wr_ptr_q;
  reg             rd_ptr_q;
  reg [1:0]       count_q;
  wire            push;
  wire            pop;

  assign in_ready  = (count_q != 2'd2);
  assign out_valid = (count_q != 2'd0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push & ~pop) begin
        count_q <= count_q + 2'd1;
      end else if (pop & ~push) begin
        count_q <= count_q - 2'd1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule

`default_nettype wire

// ===== src/conv_ctrl.v
// Converter control mode selection, serial registers and output clocking
`default_nettype none
`include "conv_ctrl_defs.vh"

module conv_ctrl (
  input  wire        ref_clk,
  input  wire        rst,
  // Control pins
  input  wire        extended_control_select,
  input  wire        output_edge_pin,
  input  wire        output_edge_pin_float,
  input  wire        full_scale_select_pin,
  input  wire        cal_delay_select_pin,
  input  wire        power_down_pin,
  // Serial register port
  input  wire        sclk,
  input  wire        sdata,
  input  wire        scs_n,
  // Converter cores
  input  wire [7:0]  sample_rise_data,
  input  wire [7:0]  sample_fall_data,
  input  wire        sample_valid,
  output wire        sample_ready,
  input  wire        skew_late,
  // Read side
  input  wire        read_clk,
  input  wire        read_enable,
  output reg  [7:0]  data_out,
  output reg         output_strobe,
  output reg         buffer_empty_flag,
  output reg         buffer_full_flag,
  // Analog settings
  output reg         core_enable,
  output reg  [8:0]  full_scale_code,
  output reg  [8:0]  offset_code,
  output reg  [15:0] phase_fine,
  output reg  [15:0] phase_coarse,
  output reg  [5:0]  phase_trim,
  output reg         cal_delay_long,
  output reg         duty_stab_enable,
  output reg         diff_reset_enable,
  output reg         res_trim_disable,
  output reg  [15:0] buffer_config
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [1:0] ext_s;
  reg [1:0] edge_s;
  reg [1:0] float_s;
  reg [1:0] fsr_s;
  reg [1:0] cal_s;
  reg [1:0] pd_s;
  reg [1:0] sclk_s;
  reg [1:0] sdata_s;
  reg [1:0] scs_s;
  reg [1:0] rclk_s;
  reg [1:0] ren_s;
  reg       sclk_prev_q;
  reg       rclk_prev_q;

  always @(posedge ref_clk) begin
    if (rst) begin
      ext_s   <= 2'h0;
      edge_s  <= 2'h0;
      float_s <= 2'h0;
      fsr_s   <= 2'h0;
      cal_s   <= 2'h0;
      pd_s    <= 2'h3;
      sclk_s  <= 2'h0;
      sdata_s <= 2'h0;
      scs_s   <= 2'h3;
      ren_s   <= 2'h0;
      sclk_prev_q <= 1'b0;
    end else begin
      ext_s   <= {ext_s[0], extended_control_select};
      edge_s  <= {edge_s[0], output_edge_pin};
      float_s <= {float_s[0], output_edge_pin_float};
      fsr_s   <= {fsr_s[0], full_scale_select_pin};
      cal_s   <= {cal_s[0], cal_delay_select_pin};
      pd_s    <= {pd_s[0], power_down_pin};
      sclk_s  <= {sclk_s[0], sclk};
      sdata_s <= {sdata_s[0], sdata};
      scs_s   <= {scs_s[0], scs_n};
      ren_s   <= {ren_s[0], read_enable};
      sclk_prev_q <= sclk_s[1];
    end
  end

  // Read clock tracked through reset: no false edge after release
  always @(posedge ref_clk) begin
    rclk_s      <= {rclk_s[0], read_clk};
    rclk_prev_q <= rclk_s[1];
  end

  wire ext_mode  = ext_s[1];
  wire powered   = ~pd_s[1];
  wire sclk_rise = sclk_s[1] & ~sclk_prev_q;
  wire rclk_rise = rclk_s[1] & ~rclk_prev_q;
  wire rclk_fall = ~rclk_s[1] & rclk_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // Serial frame receiver and register file
  reg [31:0] shift_q;
  reg [5:0]  bit_cnt_q;
  reg        frame_done_q;
  reg [15:0] cfg_q;
  reg [15:0] offset_q;
  reg [15:0] fs_q;
  reg [15:0] fine_q;
  reg [15:0] coarse_q;
  reg [15:0] tpb_q;
  wire [31:0] shift_d = {shift_q[30:0], sdata_s[1]};

  always @(posedge ref_clk) begin
    if (rst) begin
      shift_q      <= 32'h0;
      bit_cnt_q    <= 6'h0;
      frame_done_q <= 1'b0;
    end else begin
      frame_done_q <= 1'b0;
      if (scs_s[1] | ~ext_mode) begin
        bit_cnt_q <= 6'h0;
      end else if (sclk_rise) begin
        shift_q <= shift_d;
        if (bit_cnt_q == `FRAME_BITS - 6'd1) begin
          // Back-to-back frames start at the next clock
          bit_cnt_q    <= 6'h0;
          frame_done_q <= 1'b1;
        end else begin
          bit_cnt_q <= bit_cnt_q + 6'd1;
        end
      end
    end
  end

  wire        hdr_ok  = (shift_q[`HDR_HI:`HDR_LO] == `FRAME_HEADER);
  wire [3:0]  wr_addr = shift_q[`ADDR_HI:`ADDR_LO];
  wire [15:0] wr_data = shift_q[`DATA_HI:`DATA_LO];
  wire        wr_en   = frame_done_q & hdr_ok;

  // Only reset clears these; power-down leaves them intact
  always @(posedge ref_clk) begin
    if (rst) begin
      cfg_q    <= `CONFIG_RESET;
      offset_q <= `OFFSET_RESET;
      fs_q     <= `FULL_SCALE_RESET;
      fine_q   <= `PHASE_FINE_RESET;
      coarse_q <= `PHASE_COARSE_RESET;
      tpb_q    <= `TEST_BUFFER_RESET;
    end else if (wr_en) begin
      case (wr_addr)
        `ADDR_CONFIG:       cfg_q    <= wr_data;
        `ADDR_OFFSET:       offset_q <= wr_data;
        `ADDR_FULL_SCALE:   fs_q     <= wr_data;
        `ADDR_PHASE_FINE:   fine_q   <= wr_data;
        `ADDR_PHASE_COARSE: coarse_q <= wr_data;
        `ADDR_TEST_BUFFER:  tpb_q    <= wr_data;
        default:            cfg_q    <= cfg_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Effective settings per control mode
  // Mode pin is assumed static while running
  reg ddr_mode;
  reg sdr_rising;
  reg ddr_mid_phase;
  reg test_pattern_on;

  always @* begin
    if (ext_mode) begin
      ddr_mode        = ~cfg_q[`CFG_DDR_DISABLE];
      sdr_rising      = cfg_q[`CFG_OUT_EDGE];
      ddr_mid_phase   = cfg_q[`CFG_DDR_PHASE];
      test_pattern_on = tpb_q[`TP_ENABLE];
    end else begin
      ddr_mode        = float_s[1];
      sdr_rising      = edge_s[1];
      ddr_mid_phase   = 1'b0;
      test_pattern_on = 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      full_scale_code   <= `FS_CODE_PIN_LOW;
      offset_code       <= `OFFSET_CODE_ZERO;
      phase_fine        <= `PHASE_ZERO;
      phase_coarse      <= `PHASE_ZERO;
      cal_delay_long    <= 1'b0;
      duty_stab_enable  <= 1'b1;
      diff_reset_enable <= 1'b0;
      res_trim_disable  <= 1'b0;
      buffer_config     <= `TEST_BUFFER_RESET;
      core_enable       <= 1'b0;
    end else begin
      core_enable <= powered;
      if (ext_mode) begin
        full_scale_code   <= fs_q[`CODE_HI:`CODE_LO];
        offset_code       <= offset_q[`CODE_HI:`CODE_LO];
        phase_fine        <= fine_q;
        phase_coarse      <= coarse_q;
        cal_delay_long    <= 1'b0;
        duty_stab_enable  <= cfg_q[`CFG_DUTY_STAB];
        diff_reset_enable <= cfg_q[`CFG_DIFF_RESET];
        res_trim_disable  <= cfg_q[`CFG_RES_TRIM_DIS];
        buffer_config     <= tpb_q;
      end else begin
        full_scale_code   <= fsr_s[1] ? `FS_CODE_PIN_HIGH
                                      : `FS_CODE_PIN_LOW;
        offset_code       <= `OFFSET_CODE_ZERO;
        phase_fine        <= `PHASE_ZERO;
        phase_coarse      <= `PHASE_ZERO;
        cal_delay_long    <= cal_s[1];
        duty_stab_enable  <= 1'b1;
        diff_reset_enable <= 1'b0;
        res_trim_disable  <= 1'b0;
        buffer_config     <= `TEST_BUFFER_RESET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Background edge trim, stepped by a divider enable
  reg [3:0] trim_div_q;
  wire      trim_tick = (trim_div_q == `TRIM_PERIOD);

  always @(posedge ref_clk) begin
    if (rst) begin
      trim_div_q <= 4'h0;
      phase_trim <= `TRIM_MID;
    end else begin
      trim_div_q <= trim_div_q + 4'h1;
      if (trim_tick & powered) begin
        if (skew_late & (phase_trim != `TRIM_MAX)) begin
          phase_trim <= phase_trim + 6'd1;
        end else if (~skew_late & (phase_trim != `TRIM_MIN)) begin
          phase_trim <= phase_trim - 6'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample intake through the two-entry buffer
  wire [15:0] buf_out_data;
  wire        buf_out_valid;
  wire        buf_in_ready;
  wire        buf_out_ready;
  wire        intake_valid = sample_valid & powered;

  assign sample_ready = buf_in_ready & powered;

  two_entry_buffer #(
    .WIDTH (16)
  ) u_buf (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_data   ({sample_rise_data, sample_fall_data}),
    .in_valid  (intake_valid),
    .in_ready  (buf_in_ready),
    .out_data  (buf_out_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready)
  );

  ////////////////////////////////////////////////////////////////////////
  // Output strobe and word sequencing on read clock edges
  reg       second_pending_q;
  reg [7:0] second_word_q;
  reg [7:0] pattern_q;
  reg       word_adv;

  always @* begin
    if (ddr_mode) begin
      word_adv = rclk_rise;
    end else begin
      // Word moves when the strobe reaches the chosen level
      word_adv = rclk_rise & ((~output_strobe) == sdr_rising);
    end
  end

  wire adv_ok = word_adv & ren_s[1];
  assign buf_out_ready = adv_ok & ~second_pending_q;

  always @(posedge ref_clk) begin
    if (rst) begin
      output_strobe <= 1'b0;
    end else if (ddr_mode & ddr_mid_phase) begin
      if (rclk_fall) begin
        output_strobe <= ~output_strobe;
      end
    end else if (rclk_rise) begin
      output_strobe <= ~output_strobe;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      data_out          <= 8'h00;
      second_pending_q  <= 1'b0;
      second_word_q     <= 8'h00;
      pattern_q         <= `TP_SEED;
      buffer_empty_flag <= 1'b1;
      buffer_full_flag  <= 1'b0;
    end else begin
      if (adv_ok) begin
        if (test_pattern_on) begin
          data_out  <= pattern_q;
          pattern_q <= ~pattern_q;
        end else if (second_pending_q) begin
          data_out <= second_word_q;
        end else if (buf_out_valid) begin
          data_out <= buf_out_data[15:8];
        end
        if (second_pending_q) begin
          second_pending_q <= 1'b0;
        end else if (buf_out_valid) begin
          second_pending_q <= 1'b1;
          second_word_q    <= buf_out_data[7:0];
        end
      end
      if (rclk_rise) begin
        buffer_empty_flag <= ~buf_out_valid & ~second_pending_q;
        buffer_full_flag  <= ~buf_in_ready;
      end
    end
  end

endmodule

`default_nettype wire

// ===== bench/conv_ctrl_asserts.sv
// Port-level assertions for the converter control block
`default_nettype none
`include "conv_ctrl_defs.vh"
module conv_ctrl_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        extended_control_select,
  input wire logic        output_edge_pin,
  input wire logic        output_edge_pin_float,
  input wire logic        full_scale_select_pin,
  input wire logic        cal_delay_select_pin,
  input wire logic        power_down_pin,
  input wire logic        sample_valid,
  input wire logic        sample_ready,
  input wire logic        read_clk,
  input wire logic [7:0]  data_out,
  input wire logic        output_strobe,
  input wire logic        buffer_full_flag,
  input wire logic        core_enable,
  input wire logic [8:0]  full_scale_code,
  input wire logic [8:0]  offset_code,
  input wire logic [15:0] phase_fine,
  input wire logic [5:0]  phase_trim,
  input wire logic        cal_delay_long
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rc_h = 8'h00;
  wire        nrm = !extended_control_select;

  // Recent read clock levels: an output moves three cycles after an edge
  always @(posedge ref_clk) rc_h <= {rc_h[6:0], read_clk};

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  AST_PD_STOPS: assert property (
    power_down_pin [*6] |-> !sample_ready && !core_enable)
    else $error("intake still active in power down");
  AST_ACTIVE_UP: assert property (
    !power_down_pin [*6] |-> core_enable)
    else $error("core not enabled while active");
  AST_NRM_FS: assert property (
    (nrm && $stable(full_scale_select_pin)) [*6] |-> full_scale_code ==
      (full_scale_select_pin ? `FS_CODE_PIN_HIGH : `FS_CODE_PIN_LOW))
    else $error("normal full scale code wrong");
  AST_NRM_NO_ADJ: assert property (
    nrm [*6] |-> offset_code == 9'h000 && phase_fine == 16'h0000)
    else $error("adjustment active in normal control");
  AST_CAL_DELAY: assert property (
    ($stable(extended_control_select) && $stable(cal_delay_select_pin)) [*6]
      |-> cal_delay_long == (nrm && cal_delay_select_pin))
    else $error("cal delay choice wrong");
  AST_OUT_ON_RCLK: assert property (
    $changed(output_strobe) || $changed(data_out) |->
      rc_h[3] != rc_h[2])
    else $error("output moved without read clock edge");
  AST_SDR_EDGE: assert property (
    (nrm && !output_edge_pin_float && $stable(output_edge_pin)) [*8] ##0
      $changed(data_out) |-> $changed(output_strobe) &&
      output_strobe == output_edge_pin)
    else $error("single rate word on wrong strobe edge");
  AST_DDR_NRM: assert property (
    (nrm && output_edge_pin_float) [*8] ##0 $changed(data_out) |->
      $changed(output_strobe))
    else $error("double rate word not aligned to strobe");
  AST_TRIM_STEP: assert property (
    $changed(phase_trim) |-> phase_trim == $past(phase_trim) + 6'd1 ||
      phase_trim == $past(phase_trim) - 6'd1)
    else $error("trim moved by more than one step");

  C_TAKE: cover property (sample_valid && sample_ready);
  C_FULL: cover property (buffer_full_flag);
  C_PD: cover property (power_down_pin && !core_enable);
endmodule

bind conv_ctrl conv_ctrl_chk chk_u (.ref_clk, .rst, .extended_control_select,
  .output_edge_pin, .output_edge_pin_float, .full_scale_select_pin,
  .cal_delay_select_pin, .power_down_pin, .sample_valid, .sample_ready,
  .read_clk, .data_out, .output_strobe, .buffer_full_flag, .core_enable,
  .full_scale_code, .offset_code, .phase_fine, .phase_trim, .cal_delay_long);
`default_nettype wire

// ===== bench/host_link.sv
// Far-side model: serial register writer and free-running read clock
`default_nettype none
module host_link (
  input  wire logic ref_clk,
  output var  logic sclk,
  output var  logic sdata,
  output var  logic scs_n,
  output var  logic read_clk
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    scs_n = 1'b1;
  end

  // Phase offset keeps read clock edges away from ref_clk edges
  initial begin
    read_clk = 1'b0;
    #137;
    forever #400 read_clk = ~read_clk;
  end

  task automatic send(input logic [31:0] fr);
    @(negedge ref_clk);
    scs_n <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      sdata <= fr[i];
      repeat (4) @(negedge ref_clk);
      sclk <= 1'b1;
      repeat (4) @(negedge ref_clk);
      sclk <= 1'b0;
    end
    repeat (4) @(negedge ref_clk);
    scs_n <= 1'b1;
    sdata <= ~fr[0];
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_conv_ctrl.sv
// Self-checking bench for the converter control block
`default_nettype none
module tb_conv_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [4:0] pins;
    logic [8:0] fs;
    logic       cdl;
    logic [2:0] nhi;
  } row_t;
  // Pins: control select, scale, cal delay, edge float, edge
  row_t        rows [4] = '{'{5'h00, 9'h0d8, 1'b0, 3'd0},
                            '{5'h0d, 9'h128, 1'b1, 3'd4},
                            '{5'h02, 9'h0d8, 1'b0, 3'd2},
                            '{5'h1f, 9'h100, 1'b0, 3'd0}};
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        extended_control_select = 1'b0, full_scale_select_pin = 1'b0;
  logic        output_edge_pin = 1'b0, output_edge_pin_float = 1'b0;
  logic        cal_delay_select_pin = 1'b0, power_down_pin = 1'b0;
  logic        sample_valid = 1'b0, skew_late = 1'b0, read_enable = 1'b1;
  logic [7:0]  sample_rise_data = 8'h00, sample_fall_data = 8'h00;
  logic        sclk, sdata, scs_n, read_clk, sample_ready, output_strobe;
  logic        buffer_empty_flag, buffer_full_flag, core_enable, s_prev;
  logic        cal_delay_long, duty_stab_enable, diff_reset_enable;
  logic        res_trim_disable;
  logic [7:0]  data_out, d_prev = 8'h00;
  logic [8:0]  full_scale_code, offset_code;
  logic [15:0] phase_fine, phase_coarse, buffer_config;
  logic [5:0]  phase_trim;
  logic [7:0]  q[$];
  int          err_total = 0, checked = 0, n_hi = 0, n_al = 0;
  wire  [2:0]  cfg3 = {diff_reset_enable, res_trim_disable, duty_stab_enable};

  always #50 ref_clk = ~ref_clk;

  host_link pm_u (.ref_clk, .sclk, .sdata, .scs_n, .read_clk);
  conv_ctrl dut_u (.ref_clk, .rst, .extended_control_select, .output_edge_pin,
    .output_edge_pin_float, .full_scale_select_pin, .cal_delay_select_pin,
    .power_down_pin, .sclk, .sdata, .scs_n, .sample_rise_data,
    .sample_fall_data, .sample_valid, .sample_ready, .skew_late, .read_clk,
    .read_enable, .data_out, .output_strobe, .buffer_empty_flag,
    .buffer_full_flag, .core_enable, .full_scale_code, .offset_code,
    .phase_fine, .phase_coarse, .phase_trim, .cal_delay_long,
    .duty_stab_enable, .diff_reset_enable, .res_trim_disable, .buffer_config);

  // Receiver: log each new word and the strobe state beside it
  always @(posedge ref_clk) begin
    if (data_out !== d_prev) begin
      q.push_back(data_out);
      n_hi += (output_strobe === 1'b1);
      n_al += (output_strobe !== s_prev);
    end
    d_prev <= data_out;
    s_prev <= output_strobe;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d errors=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #2ms;
    err_total++;
    stop_test;
  end

  task automatic restart(input logic [4:0] p);
    @(negedge ref_clk);
    rst = 1'b1;
    {extended_control_select, full_scale_select_pin, cal_delay_select_pin,
     output_edge_pin_float, output_edge_pin} = p;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    pm_u.send({12'h001, a, d});
    repeat (8) @(negedge ref_clk);
  endtask

  task automatic put(input logic [7:0] r, f, input int lim, output bit ok);
    sample_rise_data = r;
    sample_fall_data = f;
    sample_valid = 1'b1;
    for (int k = 0; k < lim && sample_ready !== 1'b1; k++)
      @(negedge ref_clk);
    ok = (sample_ready === 1'b1);
    @(negedge ref_clk);
  endtask

  task automatic waitq(input int n);
    for (int k = 0; k < 3000 && q.size() < n; k++)
      @(negedge ref_clk);
  endtask

  task automatic flow(input logic [7:0] b, input bit cmp = 1'b1);
    bit ok;
    q = {};
    n_hi = 0;
    n_al = 0;
    put(b, b + 8'h1, 400, ok);
    put(b + 8'h2, b + 8'h3, 400, ok);
    sample_valid = 1'b0;
    waitq(4);
    for (int i = 0; i < 4 && cmp; i++)
      check(16'(q[i]), 16'(b + 8'(i)));
  endtask

  initial begin
    bit ok;
    int n;
    foreach (rows[i]) begin
      restart(rows[i].pins);
      check(16'(full_scale_code), 16'(rows[i].fs));
      check(16'(cal_delay_long), 16'(rows[i].cdl));
      check(16'(offset_code) | phase_fine | phase_coarse, 16'h0);
      check(16'(cfg3), 16'h1);
      check(buffer_config, 16'h0000);
      flow(8'h10 * 8'(i + 1));
      check(16'(n_hi), 16'(rows[i].nhi));
    end
    restart(5'h10);
    check(16'({data_out, phase_trim}), 16'h0020);
    check(16'({buffer_empty_flag, buffer_full_flag}), 16'h2);
    skew_late = 1'b1;
    wr(4'h3, 16'hff80);
    check(16'(full_scale_code), 16'h1ff);
    pm_u.send({12'h003, 4'h3, 16'h0000});
    wr(4'h4, 16'h0000);
    wr(4'h2, 16'h0080);
    check(16'(full_scale_code), 16'h1ff);
    check(16'(offset_code), 16'h001);
    wr(4'hd, 16'h1234);
    wr(4'he, 16'h8001);
    check(phase_fine, 16'h1234);
    check(phase_coarse, 16'h8001);
    check(16'(phase_trim != 6'h20), 16'h1);
    read_enable = 1'b0;
    repeat (4) @(negedge ref_clk);
    q = {};
    n = 0;
    for (int i = 0; i < 3; i++) begin
      put(8'h50 + 8'(i), 8'h60 + 8'(i), 30, ok);
      n += int'(ok);
    end
    sample_valid = 1'b0;
    check(16'(n), 16'h2);
    check(16'({buffer_full_flag, sample_ready}), 16'h2);
    power_down_pin = 1'b1;
    repeat (8) @(negedge ref_clk);
    check(16'(core_enable), 16'h0);
    read_enable = 1'b1;
    waitq(4);
    check({q[0], q[1]}, 16'h5060);
    check({q[2], q[3]}, 16'h5161);
    power_down_pin = 1'b0;
    repeat (30) @(negedge ref_clk);
    check(16'(core_enable), 16'h1);
    check(16'({buffer_empty_flag, full_scale_code}), 16'h3ff);
    wr(4'h1, 16'he7ff);
    check(16'(cfg3), 16'h6);
    flow(8'h70);
    check(16'(n_hi), 16'h4);
    wr(4'h1, 16'h92ff); // Edge bit written low with double rate
    flow(8'h80);
    check(16'({n_hi[7:0], n_al[7:0]}), 16'h0204);
    wr(4'h1, 16'h9aff);
    flow(8'h90);
    check(16'(n_al), 16'h0);
    wr(4'hf, 16'h0800);
    flow(8'ha0, 1'b0);
    check(16'(q[0] ^ q[1]), 16'hff);
    stop_test;
  end
endmodule
`default_nettype wire
